/* File: shared/pfc_pkg.sv */
// package: pll2 fractional configuration register map and field layout
package pfc_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] PFC_IDX_CONTROL_ONE = 8'h48;
    localparam logic [7:0] PFC_IDX_INT_DIV_HIGH = 8'h49;
    localparam logic [7:0] PFC_IDX_INT_DIV_LOW = 8'h4A;
    localparam logic [7:0] PFC_IDX_NUM_TOP = 8'h4B;
    localparam logic [7:0] PFC_IDX_NUM_MID = 8'h4C;
    localparam logic [7:0] PFC_IDX_NUM_BOTTOM = 8'h4D;
    localparam logic [7:0] PFC_IDX_DEN_TOP = 8'h4E;
    localparam logic [7:0] PFC_IDX_DEN_MID = 8'h4F;
    localparam logic [7:0] PFC_IDX_DEN_BOTTOM = 8'h50;
    localparam logic [7:0] PFC_IDX_MOD_CONTROL = 8'h51;
    localparam int PFC_NUM_REGS = 10;
    localparam int PFC_ADDR_LSB = 2;

    // slot numbers inside the bank (index minus first index)
    localparam logic [3:0] PFC_SLOT_CONTROL_ONE = 4'h0;
    localparam logic [3:0] PFC_SLOT_INT_DIV_HIGH = 4'h1;
    localparam logic [3:0] PFC_SLOT_INT_DIV_LOW = 4'h2;
    localparam logic [3:0] PFC_SLOT_NUM_TOP = 4'h3;
    localparam logic [3:0] PFC_SLOT_NUM_MID = 4'h4;
    localparam logic [3:0] PFC_SLOT_NUM_BOTTOM = 4'h5;
    localparam logic [3:0] PFC_SLOT_DEN_TOP = 4'h6;
    localparam logic [3:0] PFC_SLOT_DEN_MID = 4'h7;
    localparam logic [3:0] PFC_SLOT_DEN_BOTTOM = 4'h8;
    localparam logic [3:0] PFC_SLOT_MOD_CONTROL = 4'h9;

    // reset values
    localparam logic [7:0] PFC_RST_CONTROL_ONE = 8'h18;
    localparam logic [7:0] PFC_RST_INT_DIV_HIGH = 8'h00;
    localparam logic [7:0] PFC_RST_INT_DIV_LOW = 8'h64;
    localparam logic [7:0] PFC_RST_FRAC_BYTE = 8'h00;
    localparam logic [7:0] PFC_RST_MOD_CONTROL = 8'h0C;

    // writable bit masks; clear bits are reserved
    localparam logic [7:0] PFC_MASK_CONTROL_ONE = 8'h3F;
    localparam logic [7:0] PFC_MASK_NIBBLE = 8'h0F;
    localparam logic [7:0] PFC_MASK_SIX = 8'h3F;
    localparam logic [7:0] PFC_MASK_BYTE = 8'hFF;

    // field positions
    localparam int PFC_DOUBLER_BIT = 4;
    localparam int PFC_GAIN_MSB = 3;
    localparam int PFC_GAIN_LSB = 0;
    localparam int PFC_DITHER_MSB = 3;
    localparam int PFC_DITHER_LSB = 2;
    localparam int PFC_ORDER_MSB = 1;
    localparam int PFC_ORDER_LSB = 0;

    // dither and order encodings
    typedef enum logic [1:0] {
        PFC_DITHER_WEAK = 2'b00,
        PFC_DITHER_MEDIUM = 2'b01,
        PFC_DITHER_STRONG = 2'b10,
        PFC_DITHER_OFF = 2'b11
    } pfc_dither_t;

    typedef enum logic [1:0] {
        PFC_ORDER_INTEGER = 2'b00,
        PFC_ORDER_FIRST = 2'b01,
        PFC_ORDER_SECOND = 2'b10,
        PFC_ORDER_THIRD = 2'b11
    } pfc_order_t;

    // axi response codes
    localparam logic [1:0] PFC_RESP_OKAY = 2'b00;
    localparam logic [1:0] PFC_RESP_SLVERR = 2'b10;

endpackage : pfc_pkg

/* File: logic/pfc_field_decode.sv */
// field decode: pump current, effective divide ratio and modulator status
`timescale 1ns/100ps
`default_nettype none

module pfc_field_decode
    import pfc_pkg::*;
(
    input wire logic [3:0] gain_code,
    input wire logic [11:0] int_divide,
    input wire logic [1:0] dither_select,
    input wire logic [1:0] order_select,
    input wire logic [21:0] numerator,
    input wire logic [21:0] denominator,
    output logic [7:0] pump_current_tenth_ma,
    output logic pump_code_valid,
    output logic [11:0] divide_ratio,
    output logic fractional_active,
    output logic dither_active,
    output logic frac_config_ok
);

    // pump current in tenths of a milliamp; codes outside 1..8 unsupported
    always_comb begin
        pump_code_valid = 1'b1;
        case (gain_code)
            4'h1: pump_current_tenth_ma = 8'h04;
            4'h2: pump_current_tenth_ma = 8'h08;
            4'h3: pump_current_tenth_ma = 8'h10;
            4'h4: pump_current_tenth_ma = 8'h40;
            4'h5: pump_current_tenth_ma = 8'h0C;
            4'h6: pump_current_tenth_ma = 8'h14;
            4'h7: pump_current_tenth_ma = 8'h18;
            4'h8: pump_current_tenth_ma = 8'h1C;
            default: begin
                pump_current_tenth_ma = 8'h00;
                pump_code_valid = 1'b0;
            end
        endcase
    end

    // codes zero and one both divide by one
    always_comb begin
        if (int_divide[11:1] == 11'h000) begin
            divide_ratio = 12'h001;
        end else begin
            divide_ratio = int_divide;
        end
    end

    // modulator status
    assign fractional_active = (order_select != PFC_ORDER_INTEGER);
    assign dither_active = fractional_active && (dither_select != PFC_DITHER_OFF);
    // fraction must be proper with a nonzero denominator when fractional
    assign frac_config_ok = !fractional_active || ((denominator != 22'h000000) && (numerator < denominator));

endmodule // pfc_field_decode

`default_nettype wire

/* File: logic/pfc_config_regs.sv */
// pll2 fractional configuration register bank with axi4-lite slave
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none

module pfc_config_regs
    import pfc_pkg::*;
#(
    parameter int ADDR_WIDTH = 12,
    parameter int DATA_WIDTH = 32
)
(
    input wire logic aclk,
    input wire logic aresetn,
    // write address channel
    input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // write data channel
    input wire logic [DATA_WIDTH-1:0] s_axi_wdata,
    input wire logic [DATA_WIDTH/8-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // write response channel
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read address channel
    input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // read data channel
    output logic [DATA_WIDTH-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // configuration fields toward the synthesizer
    output logic secondary_ref_doubler_en,
    output logic [3:0] pll2_pump_gain_code,
    output logic [7:0] pll2_pump_current_tenth_ma,
    output logic pll2_pump_code_valid,
    output logic [11:0] pll2_integer_divide,
    output logic [11:0] pll2_divide_ratio,
    output logic [21:0] pll2_frac_numerator,
    output logic [21:0] pll2_frac_denominator,
    output logic [1:0] pll2_dither_select,
    output logic [1:0] pll2_modulator_order,
    output logic pll2_fractional_active,
    output logic pll2_dither_active,
    output logic pll2_frac_config_ok
);

    // register bank storage, one byte per slot
    logic [7:0] bank_reg [PFC_NUM_REGS];

    // write channel holding state
    logic aw_held_reg;
    logic [ADDR_WIDTH-1:0] aw_addr_reg;
    logic w_held_reg;
    logic [7:0] w_byte_reg;
    logic w_lane_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;

    // read channel state
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic [DATA_WIDTH-1:0] rdata_reg;

    // registered field outputs
    logic [7:0] pump_current_reg;
    logic pump_code_valid_reg;
    logic [11:0] divide_ratio_reg;
    logic fractional_active_reg;
    logic dither_active_reg;
    logic frac_config_ok_reg;

    // combinational helpers
    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic wr_fire;
    logic [ADDR_WIDTH-1:0] wr_addr;
    logic [7:0] wr_byte;
    logic wr_lane;
    logic wr_hit;
    logic [3:0] wr_slot;
    logic rd_hit;
    logic [3:0] rd_slot;

    // assembled fields from the bank
    logic [11:0] int_divide_w;
    logic [21:0] numerator_w;
    logic [21:0] denominator_w;
    logic [7:0] pump_current_w;
    logic pump_code_valid_w;
    logic [11:0] divide_ratio_w;
    logic fractional_active_w;
    logic dither_active_w;
    logic frac_config_ok_w;

    // byte address to slot: hit only for aligned addresses inside the bank
    function automatic logic [4:0] addr_to_slot(input logic [ADDR_WIDTH-1:0] addr);
        logic [ADDR_WIDTH-1:0] idx;
        logic [ADDR_WIDTH-1:0] first;
        logic [ADDR_WIDTH-1:0] last;
        logic [ADDR_WIDTH-1:0] diff;
        idx = addr >> PFC_ADDR_LSB;
        first = ADDR_WIDTH'(PFC_IDX_CONTROL_ONE);
        last = ADDR_WIDTH'(PFC_IDX_MOD_CONTROL);
        diff = idx - first;
        if ((addr[PFC_ADDR_LSB-1:0] == 2'b00) && (idx >= first) && (idx <= last)) begin
            addr_to_slot = {1'b1, diff[3:0]};
        end else begin
            addr_to_slot = {1'b0, 4'h0};
        end
    endfunction

    // writable bits of each slot
    function automatic logic [7:0] slot_mask(input logic [3:0] slot);
        case (slot)
            PFC_SLOT_CONTROL_ONE: slot_mask = PFC_MASK_CONTROL_ONE;
            PFC_SLOT_INT_DIV_HIGH: slot_mask = PFC_MASK_NIBBLE;
            PFC_SLOT_NUM_TOP: slot_mask = PFC_MASK_SIX;
            PFC_SLOT_DEN_TOP: slot_mask = PFC_MASK_SIX;
            PFC_SLOT_MOD_CONTROL: slot_mask = PFC_MASK_NIBBLE;
            default: slot_mask = PFC_MASK_BYTE;
        endcase
    endfunction

    // reset value of each slot
    function automatic logic [7:0] slot_reset(input logic [3:0] slot);
        case (slot)
            PFC_SLOT_CONTROL_ONE: slot_reset = PFC_RST_CONTROL_ONE;
            PFC_SLOT_INT_DIV_HIGH: slot_reset = PFC_RST_INT_DIV_HIGH;
            PFC_SLOT_INT_DIV_LOW: slot_reset = PFC_RST_INT_DIV_LOW;
            PFC_SLOT_MOD_CONTROL: slot_reset = PFC_RST_MOD_CONTROL;
            default: slot_reset = PFC_RST_FRAC_BYTE;
        endcase
    endfunction

    // handshakes; address and data are taken in either order
    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready = !w_held_reg && !bvalid_reg;
    assign s_axi_arready = !rvalid_reg;
    assign aw_hs = s_axi_awvalid && s_axi_awready;
    assign w_hs = s_axi_wvalid && s_axi_wready;
    assign ar_hs = s_axi_arvalid && s_axi_arready;

    // write proceeds once both address and data are present
    assign wr_fire = (aw_held_reg || aw_hs) && (w_held_reg || w_hs);
    assign wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
    assign wr_byte = w_held_reg ? w_byte_reg : s_axi_wdata[7:0];
    assign wr_lane = w_held_reg ? w_lane_reg : s_axi_wstrb[0];
    assign {wr_hit, wr_slot} = addr_to_slot(wr_addr);
    assign {rd_hit, rd_slot} = addr_to_slot(s_axi_araddr);

    // write address holding
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= '0;
        end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
        end else if (aw_hs) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end
    end

    // write data holding; only the low byte lane carries register data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_reg <= 1'b0;
            w_byte_reg <= 8'h00;
            w_lane_reg <= 1'b0;
        end else if (wr_fire) begin
            w_held_reg <= 1'b0;
        end else if (w_hs) begin
            w_held_reg <= 1'b1;
            w_byte_reg <= s_axi_wdata[7:0];
            w_lane_reg <= s_axi_wstrb[0];
        end
    end

    // write response; unmapped addresses answer with slave error
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= PFC_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_hit ? PFC_RESP_OKAY : PFC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // bank storage; reserved bits are masked off on every write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < PFC_NUM_REGS; i++) begin
                bank_reg[i] <= slot_reset(4'(i));
            end
        end else if (wr_fire && wr_hit && wr_lane) begin
            bank_reg[wr_slot] <= wr_byte & slot_mask(wr_slot);
        end
    end

    // read channel; data captured at the address handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rresp_reg <= PFC_RESP_OKAY;
            rdata_reg <= '0;
        end else if (ar_hs) begin
            rvalid_reg <= 1'b1;
            if (rd_hit) begin
                rresp_reg <= PFC_RESP_OKAY;
                rdata_reg <= DATA_WIDTH'(bank_reg[rd_slot] & slot_mask(rd_slot));
            end else begin
                rresp_reg <= PFC_RESP_SLVERR;
                rdata_reg <= '0;
            end
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // bus outputs from flip-flops
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;

    // multi-register field assembly
    assign int_divide_w = {bank_reg[PFC_SLOT_INT_DIV_HIGH][3:0], bank_reg[PFC_SLOT_INT_DIV_LOW]};
    assign numerator_w = {bank_reg[PFC_SLOT_NUM_TOP][5:0], bank_reg[PFC_SLOT_NUM_MID],
                          bank_reg[PFC_SLOT_NUM_BOTTOM]};
    assign denominator_w = {bank_reg[PFC_SLOT_DEN_TOP][5:0], bank_reg[PFC_SLOT_DEN_MID],
                            bank_reg[PFC_SLOT_DEN_BOTTOM]};

    // decode of gain, divider and modulator settings
    pfc_field_decode u_decode (
        .gain_code(bank_reg[PFC_SLOT_CONTROL_ONE][PFC_GAIN_MSB:PFC_GAIN_LSB]),
        .int_divide(int_divide_w),
        .dither_select(bank_reg[PFC_SLOT_MOD_CONTROL][PFC_DITHER_MSB:PFC_DITHER_LSB]),
        .order_select(bank_reg[PFC_SLOT_MOD_CONTROL][PFC_ORDER_MSB:PFC_ORDER_LSB]),
        .numerator(numerator_w),
        .denominator(denominator_w),
        .pump_current_tenth_ma(pump_current_w),
        .pump_code_valid(pump_code_valid_w),
        .divide_ratio(divide_ratio_w),
        .fractional_active(fractional_active_w),
        .dither_active(dither_active_w),
        .frac_config_ok(frac_config_ok_w)
    );

    // decoded values are registered one cycle behind the bank
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pump_current_reg <= 8'h1C;
            pump_code_valid_reg <= 1'b1;
            divide_ratio_reg <= 12'h064;
            fractional_active_reg <= 1'b0;
            dither_active_reg <= 1'b0;
            frac_config_ok_reg <= 1'b1;
        end else begin
            pump_current_reg <= pump_current_w;
            pump_code_valid_reg <= pump_code_valid_w;
            divide_ratio_reg <= divide_ratio_w;
            fractional_active_reg <= fractional_active_w;
            dither_active_reg <= dither_active_w;
            frac_config_ok_reg <= frac_config_ok_w;
        end
    end

    // raw fields straight from bank flip-flops
    assign secondary_ref_doubler_en = bank_reg[PFC_SLOT_CONTROL_ONE][PFC_DOUBLER_BIT];
    assign pll2_pump_gain_code = bank_reg[PFC_SLOT_CONTROL_ONE][PFC_GAIN_MSB:PFC_GAIN_LSB];
    assign pll2_integer_divide = int_divide_w;
    assign pll2_frac_numerator = numerator_w;
    assign pll2_frac_denominator = denominator_w;
    assign pll2_dither_select = bank_reg[PFC_SLOT_MOD_CONTROL][PFC_DITHER_MSB:PFC_DITHER_LSB];
    assign pll2_modulator_order = bank_reg[PFC_SLOT_MOD_CONTROL][PFC_ORDER_MSB:PFC_ORDER_LSB];

    // decoded outputs
    assign pll2_pump_current_tenth_ma = pump_current_reg;
    assign pll2_pump_code_valid = pump_code_valid_reg;
    assign pll2_divide_ratio = divide_ratio_reg;
    assign pll2_fractional_active = fractional_active_reg;
    assign pll2_dither_active = dither_active_reg;
    assign pll2_frac_config_ok = frac_config_ok_reg;

endmodule // pfc_config_regs

`default_nettype wire

/* File: tb/pfc_config_regs_checker.sv */
// assertion checker for the pll2 configuration register bank
`timescale 1ns/100ps
`default_nettype none

module pfc_config_regs_checker
    import pfc_pkg::*;
#(
    parameter int DATA_WIDTH = 32
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [DATA_WIDTH-1:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [3:0] pll2_pump_gain_code,
    input wire logic pll2_pump_code_valid,
    input wire logic [11:0] pll2_integer_divide,
    input wire logic [11:0] pll2_divide_ratio,
    input wire logic [21:0] pll2_frac_numerator,
    input wire logic [21:0] pll2_frac_denominator,
    input wire logic [1:0] pll2_dither_select,
    input wire logic [1:0] pll2_modulator_order,
    input wire logic pll2_fractional_active,
    input wire logic pll2_dither_active,
    input wire logic pll2_frac_config_ok
);
    // reset seen high at the previous edge; keeps $past away from reset-time values
    logic rst_seen_reg;
    always_ff @(posedge aclk) begin
        rst_seen_reg <= aresetn;
    end

    // one clock domain for every check
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn || !rst_seen_reg);

    // bus answers and holding
    write_answer_a:
        assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
        else $error("no write response after both channels taken");
    read_answer_a:
        assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("no read data one cycle after address taken");
    bresp_hold_a:
        assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before bready");
    rdata_hold_a:
        assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before rready");

    // decoded outputs follow fields one cycle later
    ratio_decode_a:
        assert property (pll2_divide_ratio == ($past(pll2_integer_divide) < 12'h002 ? 12'h001
                                                : $past(pll2_integer_divide)))
        else $error("divide ratio wrong");
    code_valid_a:
        assert property (pll2_pump_code_valid == ($past(pll2_pump_gain_code) inside {[4'h1:4'h8]}))
        else $error("pump code valid wrong");
    order_active_a:
        assert property (pll2_fractional_active == ($past(pll2_modulator_order) != 2'b00))
        else $error("fractional active wrong");
    dither_active_a:
        assert property (pll2_dither_active == ($past(pll2_modulator_order) != 2'b00
                                                && $past(pll2_dither_select) != 2'b11))
        else $error("dither active wrong");
    config_ok_a:
        assert property (pll2_frac_config_ok == ($past(pll2_modulator_order) == 2'b00
            || ($past(pll2_frac_denominator) != 22'h0
            && $past(pll2_frac_numerator) < $past(pll2_frac_denominator))))
        else $error("fraction check wrong");
    field_change_a:
        assert property ($changed(pll2_integer_divide) || $changed(pll2_frac_numerator)
                         || $changed(pll2_frac_denominator) |-> $rose(s_axi_bvalid))
        else $error("field changed without a completed write");

    // main scenarios
    cover property (s_axi_bvalid && s_axi_bresp == PFC_RESP_SLVERR);
    cover property (pll2_divide_ratio == 12'h001 && pll2_integer_divide == 12'h000);
    cover property (pll2_dither_active && pll2_fractional_active);
endmodule // pfc_config_regs_checker

bind pfc_config_regs pfc_config_regs_checker #(.DATA_WIDTH(DATA_WIDTH)) i_chk (.*);

`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench for the pll2 configuration register bank
`timescale 1ns/100ps
`default_nettype none

module tb
    import pfc_pkg::*;
;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF, pll2_pump_gain_code;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, pll2_dither_select, pll2_modulator_order;
    logic secondary_ref_doubler_en, pll2_pump_code_valid, pll2_fractional_active, pll2_dither_active;
    logic pll2_frac_config_ok;
    logic [7:0] pll2_pump_current_tenth_ma;
    logic [11:0] pll2_integer_divide, pll2_divide_ratio;
    logic [21:0] pll2_frac_numerator, pll2_frac_denominator;
    int errors = 0, cmp_count = 0, cycles = 0;
    // raise bready or rready only after the answer is seen
    logic slow_ack = 1'b0;
    // reset values, readable masks, pump currents and fraction bytes
    logic [7:0] rst_v [10] = '{8'h18, 8'h00, 8'h64, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0C};
    logic [7:0] msk_v [10] = '{8'h3F, 8'h0F, 8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'h0F};
    logic [7:0] cur_v [16] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h40, 8'h0C, 8'h14, 8'h18, 8'h1C,
                               8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] frac_v [6] = '{8'h2A, 8'h5C, 8'h13, 8'h15, 8'hC3, 8'h7E};

    pfc_config_regs i_dut (.*);

    // 25 MHz clock
    initial begin
        forever #20 aclk = ~aclk;
    end

    task automatic final_report;
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // hang guard
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            final_report();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [11:0] ad(input int i);
        return 12'h120 + 12'(i * 4);
    endfunction

    // write; handshakes judged from settled values before each edge
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ah, wh, bh, bv;
        logic [1:0] rs;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= !slow_ack;
        do begin
            @(negedge aclk);
            ah = s_axi_awvalid && s_axi_awready;
            wh = s_axi_wvalid && s_axi_wready;
            bv = s_axi_bvalid;
            bh = bv && s_axi_bready;
            rs = s_axi_bresp;
            @(posedge aclk);
            if (ah) s_axi_awvalid <= 1'b0;
            if (wh) s_axi_wvalid <= 1'b0;
            if (bv && !bh) s_axi_bready <= 1'b1;
        end while (!bh);
        s_axi_bready <= 1'b0;
        chk(32'(rs), 32'(er));
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ah, rh, rvv;
        logic [1:0] rs;
        logic [31:0] rv;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= !slow_ack;
        do begin
            @(negedge aclk);
            ah = s_axi_arvalid && s_axi_arready;
            rvv = s_axi_rvalid;
            rh = rvv && s_axi_rready;
            rs = s_axi_rresp;
            rv = s_axi_rdata;
            @(posedge aclk);
            if (ah) s_axi_arvalid <= 1'b0;
            if (rvv && !rh) s_axi_rready <= 1'b1;
        end while (!rh);
        s_axi_rready <= 1'b0;
        chk(rv, ed);
        chk(32'(rs), 32'(er));
    endtask

    initial begin
        int i;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        // values straight after reset
        chk(32'(secondary_ref_doubler_en), 32'h1);
        chk(32'(pll2_pump_current_tenth_ma), 32'h1C);
        chk(32'(pll2_integer_divide), 32'h064);
        chk(32'(pll2_frac_numerator), 32'h0);
        chk(32'(pll2_frac_denominator), 32'h0);
        chk(32'(pll2_dither_select), 32'h3);
        chk(32'(pll2_modulator_order), 32'h0);
        for (i = 0; i < 10; i++) rd(ad(i), 32'(rst_v[i]), PFC_RESP_OKAY);
        // all ones, reserved bits must read zero
        for (i = 0; i < 10; i++) begin
            wr(ad(i), 32'hFFFFFFFF, PFC_RESP_OKAY);
            rd(ad(i), 32'(msk_v[i]), PFC_RESP_OKAY);
        end
        @(negedge aclk);
        chk(32'(pll2_divide_ratio), 32'hFFF);
        chk(32'(pll2_frac_numerator), 32'h3FFFFF);
        chk(32'(pll2_frac_denominator), 32'h3FFFFF);
        // every pump gain code with the doubler off
        for (i = 0; i < 16; i++) begin
            wr(ad(0), 32'(i), PFC_RESP_OKAY);
            @(negedge aclk);
            chk(32'(secondary_ref_doubler_en), 32'h0);
            chk(32'(pll2_pump_gain_code), 32'(i));
            chk(32'(pll2_pump_current_tenth_ma), 32'(cur_v[i]));
            chk(32'(pll2_pump_code_valid), 32'(i >= 1 && i <= 8));
        end
        // divider boundary codes
        wr(ad(1), 32'h0, PFC_RESP_OKAY);
        for (i = 0; i < 3; i++) begin
            wr(ad(2), 32'(i), PFC_RESP_OKAY);
            @(negedge aclk);
            chk(32'(pll2_divide_ratio), 32'(i < 2 ? 1 : i));
        end
        wr(ad(1), 32'h5, PFC_RESP_OKAY);
        wr(ad(2), 32'hA7, PFC_RESP_OKAY);
        @(negedge aclk);
        chk(32'(pll2_integer_divide), 32'h5A7);
        // fraction bytes, numerator above denominator
        for (i = 0; i < 6; i++) wr(ad(i + 3), 32'(frac_v[i]), PFC_RESP_OKAY);
        @(negedge aclk);
        chk(32'(pll2_frac_numerator), 32'h2A5C13);
        chk(32'(pll2_frac_denominator), 32'h15C37E);
        // every dither and order code
        for (i = 0; i < 16; i++) begin
            wr(ad(9), 32'(i), PFC_RESP_OKAY);
            @(negedge aclk);
            chk(32'(pll2_dither_select), 32'(i / 4));
            chk(32'(pll2_modulator_order), 32'(i % 4));
            chk(32'(pll2_fractional_active), 32'(i % 4 != 0));
            chk(32'(pll2_dither_active), 32'(i % 4 != 0 && i / 4 != 3));
            chk(32'(pll2_frac_config_ok), 32'(i % 4 == 0));
        end
        wr(ad(3), 32'h0, PFC_RESP_OKAY);
        @(negedge aclk);
        chk(32'(pll2_frac_config_ok), 32'h1);
        // two refused accesses answered late, a misaligned read answered at once, and a write with the low strobe off
        slow_ack = 1'b1;
        wr(12'h148, 32'h55, PFC_RESP_SLVERR);
        rd(12'h148, 32'h0, PFC_RESP_SLVERR);
        slow_ack = 1'b0;
        rd(12'h121, 32'h0, PFC_RESP_SLVERR);
        s_axi_wstrb <= 4'hE;
        wr(ad(2), 32'h33, PFC_RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        rd(ad(2), 32'hA7, PFC_RESP_OKAY);
        // second reset in mid-run
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(ad(2), 32'h64, PFC_RESP_OKAY);
        rd(ad(9), 32'h0C, PFC_RESP_OKAY);
        final_report();
    end
endmodule // tb

`default_nettype wire
